// >>> shift_seq_defines.svh
// Register offsets, field positions, codes and preset values of the sequencer
`ifndef SHIFT_SEQ_DEFINES_SVH
`define SHIFT_SEQ_DEFINES_SVH

`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_ACC 8'h08
`define OFF_LOWQ 8'h0c
`define OFF_OPERAND 8'h10
`define OFF_COUNT 8'h14

`define CTRL_FUNC_LSB 0
`define CTRL_FUNC_MSB 5
`define CTRL_DESIG_LSB 6
`define CTRL_DESIG_MSB 7
`define CTRL_START_BIT 8

`define STAT_BUSY_BIT 0
`define STAT_BADOP_BIT 1
`define STAT_BORROW_BIT 2
`define STAT_NIB_LSB 4
`define STAT_NIB_MSB 7

`define FUNC_RSHIFT_MUL 6'h08
`define FUNC_LSHIFT_DIV 6'h09
`define DESIG_LOWQ 2'h0
`define DESIG_ACC 2'h1
`define DESIG_PAIR 2'h2
`define DESIG_MULDIV 2'h3

`define WORD_ZERO 15'h0000
`define DIV_PRESET 15'h000f
`define NIB_ZERO 4'h0
`define NIB_ONE 4'h1
`define READ_ZERO 32'h00000000

`endif

// >>> shift_seq_pkg.sv
// Types shared by the shift, multiply and divide sequencer
package shift_seq_pkg;

    typedef logic [14:0] word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_UPPER = 2'b10,
        ST_WRITE = 2'b11
    } seq_state_t;

    typedef enum logic [1:0] {
        OP_MUL = 2'b00,
        OP_ROT = 2'b01,
        OP_PAIR = 2'b10,
        OP_DIV = 2'b11
    } op_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

// >>> count_step_adder.sv
// Count adder register: holds the complemented nibble and returns the original nibble less one
`timescale 1ns/1ps
module count_step_adder (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [3:0] countIn,
    output logic [3:0] decremented
);
    logic [3:0] sumReg;
    logic [3:0] sumNext;
    logic [3:0] plusOne;

    always_comb begin
        sumNext = load ? ~countIn : sumReg;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sumReg <= 4'h0;
        end else begin
            sumReg <= sumNext;
        end
    end

    // Carry out of the nibble is dropped, so zero wraps to all ones
    assign plusOne = sumReg + 4'h1;
    assign decremented = ~plusOne;
endmodule

// >>> shift_multiply_divide_sequencer.sv
// Iterative multiply, left shift and divide sequencer behind an APB slave
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "shift_seq_defines.svh"
module shift_multiply_divide_sequencer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire shift_seq_pkg::apb_req_t apbReq,
    output shift_seq_pkg::apb_rsp_t apbRsp
);
    import shift_seq_pkg::*;

    seq_state_t state_reg, state_next;
    op_t op_reg, op_next;
    word_t acc_reg, acc_next;
    word_t lowQ_reg, lowQ_next;
    word_t operand_reg, operand_next;
    word_t count_reg, count_next;
    word_t xReg_reg, xReg_next;
    logic xTop_reg, xTop_next;
    logic mBit_reg, mBit_next;
    logic wrapBitLatch_reg, wrapBitLatch_next;
    logic rotAcc_reg, rotAcc_next;
    logic badOp_reg, badOp_next;
    logic borrow_reg, borrow_next;
    apb_rsp_t rsp_reg, rsp_next;

    logic setupPhase;
    logic writeTaken;
    logic startReq;
    logic [5:0] funcCode;
    logic [1:0] desigCode;
    logic [3:0] shiftCountNibble;
    logic [3:0] decNibble;
    logic loadCountAdder;
    logic [15:0] partial;
    logic endAroundBorrow;
    logic [15:0] diffWide;
    word_t addSum;
    logic mapped;
    logic [31:0] readData;

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign writeTaken = apbReq.psel & apbReq.penable & rsp_reg.pready
        & apbReq.pwrite;
    assign funcCode = apbReq.pwdata[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB];
    assign desigCode = apbReq.pwdata[`CTRL_DESIG_MSB:`CTRL_DESIG_LSB];
    assign startReq = writeTaken && apbReq.paddr == `OFF_CTRL
        && apbReq.pwdata[`CTRL_START_BIT] && state_reg == ST_IDLE;
    assign shiftCountNibble = count_reg[3:0];
    assign loadCountAdder = state_reg == ST_LOW;

    // Count adder lives apart so the decrement path is one small unit
    count_step_adder countAdder (
        .clock(clock),
        .sys_rst(sys_rst),
        .load(loadCountAdder),
        .countIn(shiftCountNibble),
        .decremented(decNibble)
    );

    // Divide compare: partial dividend is one bit wider than the registers
    assign partial = {xTop_reg, xReg_reg};
    assign diffWide = partial - {1'b0, operand_reg};
    assign endAroundBorrow = partial < {1'b0, operand_reg};
    assign addSum = xReg_reg + operand_reg;

    always_comb begin
        mapped = 1'b1;
        readData = `READ_ZERO;
        case (apbReq.paddr)
            `OFF_CTRL: readData = `READ_ZERO;
            `OFF_STATUS: begin
                readData[`STAT_BUSY_BIT] = state_reg != ST_IDLE;
                readData[`STAT_BADOP_BIT] = badOp_reg;
                readData[`STAT_BORROW_BIT] = borrow_reg;
                readData[`STAT_NIB_MSB:`STAT_NIB_LSB] = shiftCountNibble;
            end
            `OFF_ACC: readData[14:0] = acc_reg;
            `OFF_LOWQ: readData[14:0] = lowQ_reg;
            `OFF_OPERAND: readData[14:0] = operand_reg;
            `OFF_COUNT: readData[14:0] = count_reg;
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait state: answer in the first access cycle
    always_comb begin
        rsp_next.pready = setupPhase;
        rsp_next.pslverr = setupPhase & ~mapped;
        rsp_next.prdata = (setupPhase & ~apbReq.pwrite) ? readData
            : `READ_ZERO;
    end

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        acc_next = acc_reg;
        lowQ_next = lowQ_reg;
        operand_next = operand_reg;
        count_next = count_reg;
        xReg_next = xReg_reg;
        xTop_next = xTop_reg;
        mBit_next = mBit_reg;
        wrapBitLatch_next = wrapBitLatch_reg;
        rotAcc_next = rotAcc_reg;
        badOp_next = badOp_reg;
        borrow_next = borrow_reg;
        // Data registers are frozen to software while a loop runs
        if (writeTaken && state_reg == ST_IDLE) begin
            case (apbReq.paddr)
                `OFF_ACC: acc_next = apbReq.pwdata[14:0];
                `OFF_LOWQ: lowQ_next = apbReq.pwdata[14:0];
                `OFF_OPERAND: operand_next = apbReq.pwdata[14:0];
                `OFF_COUNT: count_next = apbReq.pwdata[14:0];
                default: ;
            endcase
        end
        if (writeTaken && apbReq.paddr == `OFF_STATUS
            && apbReq.pwdata[`STAT_BADOP_BIT]) begin
            badOp_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (startReq) begin
                    rotAcc_next = desigCode == `DESIG_ACC;
                    if (funcCode == `FUNC_RSHIFT_MUL
                        && desigCode == `DESIG_MULDIV) begin
                        op_next = OP_MUL;
                        count_next = `WORD_ZERO;
                        acc_next = `WORD_ZERO;
                        state_next = ST_LOW;
                    end else if (funcCode == `FUNC_LSHIFT_DIV
                        && desigCode == `DESIG_MULDIV) begin
                        op_next = OP_DIV;
                        count_next = `DIV_PRESET;
                        state_next = ST_LOW;
                    end else if (funcCode == `FUNC_LSHIFT_DIV) begin
                        op_next = (desigCode == `DESIG_PAIR) ? OP_PAIR
                            : OP_ROT;
                        if (shiftCountNibble != `NIB_ZERO) begin
                            state_next = ST_LOW;
                        end
                    end else begin
                        // Right shifts are not handled here
                        badOp_next = 1'b1;
                    end
                end
            end
            ST_LOW: begin
                // Lower register goes first, accumulator for an accumulator rotate; count copied to the adder
                case (op_reg)
                    OP_MUL: begin
                        xReg_next = {acc_reg[0], lowQ_reg[14:1]};
                        mBit_next = lowQ_reg[0];
                    end
                    OP_DIV: xReg_next = {lowQ_reg[13:0], 1'b0};
                    OP_PAIR: begin
                        wrapBitLatch_next = lowQ_reg[14];
                        xReg_next = {lowQ_reg[13:0], acc_reg[14]};
                    end
                    default: begin
                        xReg_next = rotAcc_reg
                            ? {acc_reg[13:0], acc_reg[14]}
                            : {lowQ_reg[13:0], lowQ_reg[14]};
                    end
                endcase
                state_next = ST_UPPER;
            end
            ST_UPPER: begin
                count_next = {11'h000, decNibble};
                if (op_reg == OP_ROT && rotAcc_reg) begin
                    acc_next = xReg_reg;
                end else begin
                    lowQ_next = xReg_reg;
                end
                case (op_reg)
                    OP_MUL: xReg_next = {acc_reg[14], acc_reg[14:1]};
                    OP_DIV: begin
                        xTop_next = acc_reg[14];
                        xReg_next = {acc_reg[13:0], lowQ_reg[14]};
                    end
                    OP_PAIR: begin
                        xReg_next = {acc_reg[13:0], wrapBitLatch_reg};
                    end
                    default: ;
                endcase
                state_next = ST_WRITE;
            end
            ST_WRITE: begin
                case (op_reg)
                    OP_MUL: acc_next = mBit_reg ? addSum : xReg_reg;
                    OP_DIV: begin
                        borrow_next = endAroundBorrow;
                        if (!endAroundBorrow) begin
                            acc_next = diffWide[14:0];
                            lowQ_next[0] = 1'b1;
                        end else begin
                            acc_next = xReg_reg;
                        end
                    end
                    OP_PAIR: acc_next = xReg_reg;
                    default: ;
                endcase
                // Sixteen passes for multiply, fifteen for divide
                state_next = (shiftCountNibble != `NIB_ZERO) ? ST_LOW
                    : ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_MUL;
            acc_reg <= `WORD_ZERO;
            lowQ_reg <= `WORD_ZERO;
            operand_reg <= `WORD_ZERO;
            count_reg <= `WORD_ZERO;
            xReg_reg <= `WORD_ZERO;
            xTop_reg <= 1'b0;
            mBit_reg <= 1'b0;
            wrapBitLatch_reg <= 1'b0;
            rotAcc_reg <= 1'b0;
            badOp_reg <= 1'b0;
            borrow_reg <= 1'b0;
            rsp_reg <= '0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            acc_reg <= acc_next;
            lowQ_reg <= lowQ_next;
            operand_reg <= operand_next;
            count_reg <= count_next;
            xReg_reg <= xReg_next;
            xTop_reg <= xTop_next;
            mBit_reg <= mBit_next;
            wrapBitLatch_reg <= wrapBitLatch_next;
            rotAcc_reg <= rotAcc_next;
            badOp_reg <= badOp_next;
            borrow_reg <= borrow_next;
            rsp_reg <= rsp_next;
        end
    end

    assign apbRsp = rsp_reg;

    // Pass counter used only by the checks below
    logic [4:0] passCount;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            passCount <= 5'h00;
        end else if (startReq) begin
            passCount <= 5'h00;
        end else if (state_reg == ST_WRITE) begin
            passCount <= passCount + 5'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_mul_clear;
        startReq && funcCode == `FUNC_RSHIFT_MUL && desigCode == `DESIG_MULDIV
            |=> count_reg == `WORD_ZERO && acc_reg == `WORD_ZERO;
    endproperty
    a_mul_clear: assert property (p_mul_clear)
        else $error("multiply start did not clear count and accumulator");

    property p_div_preset;
        startReq && funcCode == `FUNC_LSHIFT_DIV && desigCode == `DESIG_MULDIV
            |=> count_reg == `DIV_PRESET;
    endproperty
    a_div_preset: assert property (p_div_preset)
        else $error("divide start did not preset count");

    property p_zero_lshift;
        startReq && funcCode == `FUNC_LSHIFT_DIV && desigCode != `DESIG_MULDIV
            && shiftCountNibble == `NIB_ZERO |=> state_reg == ST_IDLE;
    endproperty
    a_zero_lshift: assert property (p_zero_lshift)
        else $error("zero count left shift started a loop");

    property p_decrement;
        state_reg == ST_LOW |-> ##2
            count_reg[3:0] == $past(count_reg[3:0], 2) - 4'h1;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("count nibble not decremented by one");

    property p_loop;
        state_reg == ST_WRITE |=> (state_reg == ST_LOW)
            == ($past(shiftCountNibble) != `NIB_ZERO);
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop decision does not follow count nibble");

    property p_mul_add;
        state_reg == ST_WRITE && op_reg == OP_MUL
            |=> acc_reg == ($past(mBit_reg) ? $past(addSum) : $past(xReg_reg));
    endproperty
    a_mul_add: assert property (p_mul_add)
        else $error("multiply accumulator update wrong");

    property p_rotate;
        state_reg == ST_LOW && op_reg == OP_ROT && rotAcc_reg |-> ##2
            acc_reg == {$past(acc_reg[13:0], 2), $past(acc_reg[14], 2)};
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("accumulator left shift is not circular");

    property p_mul_passes;
        state_reg == ST_WRITE && op_reg == OP_MUL
            && shiftCountNibble == `NIB_ZERO |-> passCount == 5'h0f;
    endproperty
    a_mul_passes: assert property (p_mul_passes)
        else $error("multiply did not take sixteen passes");

    property p_div_passes;
        state_reg == ST_WRITE && op_reg == OP_DIV
            && shiftCountNibble == `NIB_ZERO |-> passCount == 5'h0e;
    endproperty
    a_div_passes: assert property (p_div_passes)
        else $error("divide did not take fifteen passes");

    property p_quot_bit;
        state_reg == ST_WRITE && op_reg == OP_DIV && !endAroundBorrow
            |=> lowQ_reg[0] && acc_reg == $past(diffWide[14:0]);
    endproperty
    a_quot_bit: assert property (p_quot_bit)
        else $error("partial division not recorded");

    c_mul_done: cover property (state_reg == ST_WRITE && op_reg == OP_MUL
        && shiftCountNibble == `NIB_ZERO);
    c_div_done: cover property (state_reg == ST_WRITE && op_reg == OP_DIV
        && shiftCountNibble == `NIB_ZERO);
    c_pair_pass: cover property (state_reg == ST_WRITE && op_reg == OP_PAIR);
    c_zero_shift: cover property (startReq && funcCode == `FUNC_LSHIFT_DIV
        && desigCode == `DESIG_ACC && shiftCountNibble == `NIB_ZERO);
endmodule

// >>> control_master_model.sv
// Control sequencer model: APB master that issues operations and waits
`timescale 1ns/1ps
`include "shift_seq_defines.svh"
module control_master_model (
    input wire logic clock,
    input wire logic slow,
    input wire shift_seq_pkg::apb_rsp_t apbRsp,
    output shift_seq_pkg::apb_req_t apbReq,
    output logic timedOut
);
    import shift_seq_pkg::*;

    initial begin
        apbReq = '0;
        timedOut = 1'b0;
    end

    // Request is held from setup until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] addr,
            input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        if (slow) begin
            @(posedge clock);
        end
        @(posedge clock);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= addr;
        apbReq.pwdata <= wd;
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        if (apbRsp.pready !== 1'b1) begin
            timedOut <= 1'b1;
        end
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    // Codes stay put until busy drops; only then does control move on
    task automatic runOp(input logic [5:0] func, input logic [1:0] desig);
        logic [31:0] st;
        logic e;
        int n;
        xfer(1'b1, `OFF_CTRL, {23'h0, 1'b1, desig, func}, st, e);
        n = 0;
        do begin
            xfer(1'b0, `OFF_STATUS, 32'h0, st, e);
            n++;
        end while (st[`STAT_BUSY_BIT] !== 1'b0 && n < 100);
        if (st[`STAT_BUSY_BIT] !== 1'b0) begin
            timedOut <= 1'b1;
        end
    endtask
endmodule

// >>> shift_multiply_divide_sequencer_tb.sv
// Self-checking bench for the shift, multiply and divide sequencer
`timescale 1ns/1ps
`include "shift_seq_defines.svh"
module shift_multiply_divide_sequencer_tb;
    import shift_seq_pkg::*;

    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic slow = 1'b0;
    logic timedOut;
    apb_req_t apbReq;
    apb_rsp_t apbRsp;
    int errCount = 0;
    int checksDone = 0;
    int cnt[4] = '{0, 1, 7, 15};
    logic [31:0] rd;
    logic e;

    always #4 clock = ~clock;

    shift_multiply_divide_sequencer i_dut (
        .clock(clock),
        .sys_rst(sysRst),
        .apbReq(apbReq),
        .apbRsp(apbRsp)
    );

    control_master_model i_ctl (
        .clock(clock),
        .slow(slow),
        .apbRsp(apbRsp),
        .apbReq(apbReq),
        .timedOut(timedOut)
    );

    task automatic testDone();
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic regWr(input logic [7:0] addr, input word_t v);
        i_ctl.xfer(1'b1, addr, {17'h0, v}, rd, e);
    endtask

    // Upper bits of every register must read as zero
    task automatic regRd(input logic [7:0] addr, input word_t v);
        i_ctl.xfer(1'b0, addr, 32'h0, rd, e);
        check(rd, {17'h0, v});
    endtask

    task automatic setRegs(input word_t av, input word_t qv, input word_t dv,
            input word_t zv);
        regWr(`OFF_ACC, av);
        regWr(`OFF_LOWQ, qv);
        regWr(`OFF_OPERAND, dv);
        regWr(`OFF_COUNT, zv);
    endtask

    // Stale accumulator and count must be cleared by the operation itself
    task automatic mulCase(input word_t dv, input word_t qv);
        logic [29:0] p;
        p = 30'(dv) * 30'(qv);
        setRegs(15'h1111, qv, dv, 15'h0005);
        i_ctl.runOp(`FUNC_RSHIFT_MUL, `DESIG_MULDIV);
        regRd(`OFF_ACC, p[29:15]);
        regRd(`OFF_LOWQ, p[14:0]);
        regRd(`OFF_COUNT, 15'h0000);
        regRd(`OFF_OPERAND, dv);
    endtask

    // A wrong preset of the count gives the wrong number of passes
    task automatic divCase(input word_t av, input word_t qv, input word_t dv);
        logic [29:0] n;
        word_t q;
        n = {av, qv};
        q = 15'(n / 30'(dv));
        setRegs(av, qv, dv, 15'h0003);
        i_ctl.runOp(`FUNC_LSHIFT_DIV, `DESIG_MULDIV);
        regRd(`OFF_LOWQ, q);
        regRd(`OFF_ACC, 15'(n % 30'(dv)));
        regRd(`OFF_COUNT, 15'h0000);
        // Borrow flag is set when the last partial division failed
        regRd(`OFF_STATUS, q[0] ? 15'h0000 : 15'h0004);
    endtask

    // Upper count bits are set so only the low nibble may matter
    task automatic rotCase(input logic [1:0] dg, input int n);
        word_t ea;
        word_t eq;
        ea = 15'h4321;
        eq = 15'h0f0f;
        setRegs(ea, eq, 15'h0000, 15'h7ff0 | 15'(n));
        regRd(`OFF_STATUS, 15'(n) << 4);
        i_ctl.runOp(`FUNC_LSHIFT_DIV, dg);
        for (int i = 0; i < n; i++) begin
            if (dg == `DESIG_LOWQ) begin
                eq = {eq[13:0], eq[14]};
            end else if (dg == `DESIG_ACC) begin
                ea = {ea[13:0], ea[14]};
            end else begin
                {ea, eq} = {ea[13:0], eq[14], eq[13:0], ea[14]};
            end
        end
        regRd(`OFF_ACC, ea);
        regRd(`OFF_LOWQ, eq);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        sysRst <= 1'b0;
        regRd(`OFF_STATUS, 15'h0000);
        regRd(`OFF_ACC, 15'h0000);
        i_ctl.xfer(1'b1, `OFF_ACC, 32'hffffffff, rd, e);
        regRd(`OFF_ACC, 15'h7fff);
        i_ctl.xfer(1'b0, 8'h18, 32'h0, rd, e);
        check(rd, 32'h00000000);
        check({31'h0, e}, 32'h00000001);
        mulCase(15'h000f, 15'h000e);
        mulCase(15'h0fed, 15'h2d4b);
        slow <= 1'b1;
        for (int dg = 0; dg < 3; dg++) begin
            foreach (cnt[i]) begin
                rotCase(2'(dg), cnt[i]);
            end
        end
        slow <= 1'b0;
        divCase(15'h0000, 15'h00d2, 15'h000e);
        divCase(15'h0005, 15'h1234, 15'h0009);
        // Borrow of the last divide stays visible beside the bad code flag
        i_ctl.runOp(6'h00, 2'h0);
        regRd(`OFF_STATUS, 15'h0006);
        regWr(`OFF_STATUS, 15'h0002);
        regRd(`OFF_STATUS, 15'h0004);
        testDone();
    end

    // A hung handshake or operation ends the run as a failure
    always @(posedge clock) begin
        if (timedOut) begin
            errCount++;
            testDone();
        end
    end
endmodule
